// ==== rtl/fmp_protect.sv ====
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module fmp_protect
  import fmp_pkg::*;
#(
  parameter int FRAM_AW = AW
) (
  // system
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // memory access check
  input  wire fmp_req_t    req,
  input  wire logic [31:0] memRdata,
  output fmp_resp_t        resp,
  output logic [31:0]      chkRdata,
  // system events
  output logic             pucReq,
  output logic             irq
);
  // the check port and the region index are sized from the package width,
  // so any other width is refused while the design is built
  if (FRAM_AW != AW || AW - REGION_SHIFT != RG_W) begin : g_bad_width
    $error("FRAM_AW must equal package AW");
  end

  logic [11:0]   rights_q;
  logic          infoRd_q;
  logic [AW-1:0] b1_q;
  logic [AW-1:0] b2_q;
  logic          segEn_q;
  logic          encEn_q;
  logic [AW-1:0] encLo_q;
  logic [AW-1:0] encHi_q;
  logic [1:0]    sysCfg_q;
  logic          regionEn_q;
  logic [5:0]    regionLo_q;
  logic [5:0]    regionHi_q;
  logic [3:0]    status_q;
  logic [3:0]    mask_q;
  logic [3:0]    status_d;

  // apb decode
  wire apbWr = psel & penable & pwrite;
  wire apbRd = psel & penable & ~pwrite;
  wire hitCtl    = paddr == OFS_SEGCTL;
  wire hitB1     = paddr == OFS_SEGB1;
  wire hitB2     = paddr == OFS_SEGB2;
  wire hitRight  = paddr == OFS_SEGRIGHT;
  wire hitEncCtl = paddr == OFS_ENCCTL;
  wire hitEncLo  = paddr == OFS_ENCLO;
  wire hitEncHi  = paddr == OFS_ENCHI;
  wire hitSys    = paddr == OFS_SYSTEM_CONFIG_REG0;
  wire hitRegion = paddr == OFS_WRREGION;
  wire hitStat   = paddr == OFS_STATUS;
  wire hitMask   = paddr == OFS_MASK;
  wire hitAny = hitCtl | hitB1 | hitB2 | hitRight | hitEncCtl | hitEncLo | hitEncHi
              | hitSys | hitRegion | hitStat | hitMask;

  // write strobes: a write lands on the access edge, when pready is high
  // and the master samples it
  wire wrCtl    = apbWr & hitCtl;
  wire wrB1     = apbWr & hitB1;
  wire wrB2     = apbWr & hitB2;
  wire wrRight  = apbWr & hitRight;
  wire wrEncCtl = apbWr & hitEncCtl;
  wire wrEncLo  = apbWr & hitEncLo;
  wire wrEncHi  = apbWr & hitEncHi;
  wire wrSys    = apbWr & hitSys;
  wire wrRegion = apbWr & hitRegion;
  wire wrMask   = apbWr & hitMask;
  wire rdStat   = apbRd & hitStat;
  // the setup edge registers the answer, so the access cycle has no wait state
  wire setup    = psel & ~penable;

  // segment select: 1 below b1, 2 from b1 up to b2, 3 from b2 to the end
  function automatic logic [1:0] segOf(input logic [AW-1:0] a, input logic [AW-1:0] lo,
                                       input logic [AW-1:0] hi);
    if (a < lo) return 2'd0;
    else if (a < hi) return 2'd1;
    else return 2'd2;
  endfunction

  wire [1:0] seg = segOf(req.addr, b1_q, b2_q);
  wire [3:0] segRt = rights_q[seg*4 +: 4];
  wire segBad = segEn_q & ~req.info & (req.fetch ? ~segRt[RT_X]
              : req.write ? ~segRt[RT_W] : ~segRt[RT_R]);
  wire infoBad = segEn_q & req.info & ~req.write & ~infoRd_q;

  // half-open range test shared by target and instruction address
  function automatic logic inRange(input logic [AW-1:0] a, input logic [AW-1:0] lo,
                                   input logic [AW-1:0] hi);
    return (a >= lo) & (a < hi);
  endfunction

  // enclave: inside test on target and on the fetching instruction
  wire inEnc = inRange(req.addr, encLo_q, encHi_q);
  wire pcInEnc = inRange(req.pc, encLo_q, encHi_q);
  wire encBad = encEn_q & ~req.info & inEnc
              & ((req.master != MST_CPU) | ~pcInEnc);

  // write lock: a main-array region with 1k granularity stays writable when enabled, the info lock ignores it;
  // region bounds are kB indices, the upper one exclusive
  wire [5:0] kb = req.addr[AW-1:REGION_SHIFT];
  wire inRegion = regionEn_q & (kb >= regionLo_q) & (kb < regionHi_q);
  wire mainLocked = sysCfg_q[SC_MAIN] & ~inRegion;
  wire infoLocked = sysCfg_q[SC_INFO];
  // fetches never program the array, so the lock ignores them
  wire wlkBad = req.write & ~req.fetch & (req.info ? infoLocked : mainLocked);

  wire denyAny = req.valid & (segBad | infoBad | encBad | wlkBad);
  wire segVs = segBad & segRt[RT_VS];

  always_comb begin
    status_d = status_q;
    if (rdStat) status_d = 4'h0;
    if (req.valid & segBad) status_d[ST_SEG] = 1'b1;
    if (req.valid & encBad) status_d[ST_ENC] = 1'b1;
    if (req.valid & wlkBad) status_d[ST_WLK] = 1'b1;
    if (req.valid & infoBad) status_d[ST_INFO] = 1'b1;
  end

  // read words; status shows its next value, so an event that lands on the
  // setup edge is reported before the access edge clears it
  wire [31:0] ctlWord    = {30'h0, infoRd_q, segEn_q};
  wire [31:0] b1Word     = {16'h0, b1_q};
  wire [31:0] b2Word     = {16'h0, b2_q};
  wire [31:0] rightWord  = {20'h0, rights_q};
  wire [31:0] encCtlWord = {31'h0, encEn_q};
  wire [31:0] encLoWord  = {16'h0, encLo_q};
  wire [31:0] encHiWord  = {16'h0, encHi_q};
  wire [31:0] sysWord    = {30'h0, sysCfg_q};
  wire [31:0] regionWord = {19'h0, regionEn_q, regionHi_q, regionLo_q};
  wire [31:0] statWord   = {28'h0, status_d};
  wire [31:0] maskWord   = {28'h0, mask_q};

  wire [31:0] rdMux =
      hitCtl    ? ctlWord :
      hitB1     ? b1Word :
      hitB2     ? b2Word :
      hitRight  ? rightWord :
      hitEncCtl ? encCtlWord :
      hitEncLo  ? encLoWord :
      hitEncHi  ? encHiWord :
      hitSys    ? sysWord :
      hitRegion ? regionWord :
      hitStat   ? statWord :
      hitMask   ? maskWord : 32'h0;

  // next values of the outputs; every output leaves through a flip-flop,
  // so all answers come one edge after what they answer
  wire        pready_d   = setup;
  wire        pslverr_d  = setup & ~hitAny;
  wire [31:0] prdata_d   = (setup & ~pwrite) ? rdMux : 32'h0;
  wire        grant_d    = req.valid & ~denyAny;
  wire [31:0] chkRdata_d = grant_d ? memRdata : READ_NEUTRAL;
  wire        pucReq_d   = req.valid & segVs;
  wire        irq_d      = |(status_d & mask_q);

  // guard enable and info read permit; reset leaves the guard open
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      segEn_q  <= 1'b0;
      infoRd_q <= RST_INFO_RD;
    end else if (wrCtl) begin
      segEn_q  <= pwdata[CTL_EN];
      infoRd_q <= pwdata[CTL_INFO_RD];
    end
  end

  // segment borders: segment 1 ends where segment 2 begins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      b1_q <= RST_BORDER;
    end else if (wrB1) begin
      b1_q <= pwdata[AW-1:0];
    end
  end

  // segment 2 ends where segment 3 begins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      b2_q <= RST_BORDER;
    end else if (wrB2) begin
      b2_q <= pwdata[AW-1:0];
    end
  end

  // rights of all three segments
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rights_q <= RST_RIGHTS;
    end else if (wrRight) begin
      rights_q <= pwdata[11:0];
    end
  end

  // enclave enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      encEn_q <= 1'b0;
    end else if (wrEncCtl) begin
      encEn_q <= pwdata[0];
    end
  end

  // enclave borders, the upper one exclusive
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      encLo_q <= RST_ENC_BORDER;
    end else if (wrEncLo) begin
      encLo_q <= pwdata[AW-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      encHi_q <= RST_ENC_BORDER;
    end else if (wrEncHi) begin
      encHi_q <= pwdata[AW-1:0];
    end
  end

  // lock bits of system config register 0
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sysCfg_q <= RST_SYSCFG;
    end else if (wrSys) begin
      sysCfg_q <= pwdata[1:0];
    end
  end

  // writable window in 1k steps
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regionEn_q <= 1'b0;
      regionLo_q <= '0;
      regionHi_q <= '0;
    end else if (wrRegion) begin
      regionLo_q <= pwdata[RG_LO +: RG_W];
      regionHi_q <= pwdata[RG_HI +: RG_W];
      regionEn_q <= pwdata[RG_EN];
    end
  end

  // interrupt mask
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= RST_MASK;
    end else if (wrMask) begin
      mask_q <= pwdata[3:0];
    end
  end

  // sticky violation flags
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= RST_STATUS;
    end else begin
      status_q <= status_d;
    end
  end

  // apb answer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= prdata_d;
      pready  <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // check port answer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      resp     <= '0;
      chkRdata <= 32'h0;
    end else begin
      resp.grant <= grant_d;
      resp.deny  <= denyAny;
      chkRdata   <= chkRdata_d;
    end
  end

  // system events
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pucReq <= 1'b0;
      irq    <= 1'b0;
    end else begin
      pucReq <= pucReq_d;
      irq    <= irq_d;
    end
  end
endmodule
`default_nettype wire

// ==== pkg/fmp_pkg.sv ====
package fmp_pkg;
  localparam int AW = 16;
  localparam logic [11:0] OFS_SEGCTL   = 12'h000;
  localparam logic [11:0] OFS_SEGB1    = 12'h004;
  localparam logic [11:0] OFS_SEGB2    = 12'h008;
  localparam logic [11:0] OFS_SEGRIGHT = 12'h00c;
  localparam logic [11:0] OFS_ENCCTL   = 12'h010;
  localparam logic [11:0] OFS_ENCLO    = 12'h014;
  localparam logic [11:0] OFS_ENCHI    = 12'h018;
  localparam logic [11:0] OFS_SYSTEM_CONFIG_REG0  = 12'h01c;
  localparam logic [11:0] OFS_WRREGION = 12'h020;
  localparam logic [11:0] OFS_STATUS   = 12'h024;
  localparam logic [11:0] OFS_MASK     = 12'h028;
  // segment rights: bit 0 read, 1 write, 2 execute, 3 violation reset select
  localparam int RT_R = 0;
  localparam int RT_W = 1;
  localparam int RT_X = 2;
  localparam int RT_VS = 3;
  localparam logic [11:0] RST_RIGHTS = 12'h777;
  // status bits
  localparam int ST_SEG = 0;
  localparam int ST_ENC = 1;
  localparam int ST_WLK = 2;
  localparam int ST_INFO = 3;
  localparam logic [3:0] RST_MASK = 4'h0;
  // system_config_reg0: bit 0 main lock, bit 1 info lock
  localparam int SC_MAIN = 0;
  localparam int SC_INFO = 1;
  localparam int REGION_SHIFT = 10;
  localparam logic [31:0] READ_NEUTRAL = 32'h0000_0000;
  // control word: bit 0 guard enable, bit 1 info read permit
  localparam int CTL_EN = 0;
  localparam int CTL_INFO_RD = 1;
  // writable region word: low and high kB index, then enable
  localparam int RG_LO = 0;
  localparam int RG_HI = 6;
  localparam int RG_EN = 12;
  localparam int RG_W = 6;
  // remaining reset values, all of them unprotected
  localparam logic RST_INFO_RD = 1'b1;
  localparam logic [AW-1:0] RST_BORDER = '0;
  localparam logic [AW-1:0] RST_ENC_BORDER = '0;
  localparam logic [1:0] RST_SYSCFG = 2'h0;
  localparam logic [3:0] RST_STATUS = 4'h0;

  typedef enum logic [1:0] {MST_CPU, MST_DMA, MST_DBG} fmp_master_t;

  typedef struct packed {
    logic              valid;
    fmp_master_t       master;
    logic              write;
    logic              fetch;
    logic              info;
    logic [AW-1:0]     addr;
    logic [AW-1:0]     pc;
  } fmp_req_t;

  typedef struct packed {
    logic grant;
    logic deny;
  } fmp_resp_t;
endpackage

// ==== testbench/fmp_protect_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module fmp_protect_props
  import fmp_pkg::*;
(
  // clock and apb
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // check port
  input wire fmp_req_t    req,
  input wire logic [31:0] memRdata,
  input wire fmp_resp_t   resp,
  input wire logic [31:0] chkRdata,
  input wire logic        pucReq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_resp_one_cycle: assert property (req.valid |=> resp.grant != resp.deny)
    else $error("no single answer after a request");
  a_resp_idle_quiet: assert property (!req.valid |=> !(resp.grant || resp.deny))
    else $error("answer without a request");
  a_deny_neutral: assert property (resp.deny |-> chkRdata == READ_NEUTRAL)
    else $error("denied access leaked data");
  a_grant_data: assert property (req.valid ##1 resp.grant |-> chkRdata == $past(memRdata))
    else $error("granted read data wrong");
  a_reset_needs_deny: assert property (pucReq |-> resp.deny)
    else $error("reset request without a denial");
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access cycle");
  a_err_zero_read: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
endmodule
bind fmp_protect fmp_protect_props chk (.mclk(mclk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req),
  .memRdata(memRdata), .resp(resp), .chkRdata(chkRdata), .pucReq(pucReq));
`default_nettype wire

// ==== testbench/fmp_master_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module fmp_master_model
  import fmp_pkg::*;
(
  input  wire logic  mclk,
  output fmp_req_t   req,
  output logic [31:0] memRdata
);
  initial req = '0;
  // idle data is inverted so a stale value never passes
  assign memRdata = req.valid ? {16'h5a5a, req.addr} : ~{16'h5a5a, req.addr};
  task automatic go(fmp_master_t m, logic w, f, i, logic [15:0] a, p);
    @(posedge mclk);
    req <= '{1'b1, m, w, f, i, a, p};
    @(posedge mclk);
    req.valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== testbench/fmp_protect_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module fmp_protect_bench;
  import fmp_pkg::*;
  logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, memRdata, chkRdata, r;
  logic pready, pslverr, pucReq, irq, e;
  fmp_req_t req;
  fmp_resp_t resp;
  int fail_count = 0, num_checks = 0;
  fmp_protect dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req(req), .memRdata(memRdata), .resp(resp),
    .chkRdata(chkRdata), .pucReq(pucReq), .irq(irq));
  fmp_master_model mdl (.mclk(mclk), .req(req), .memRdata(memRdata));
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic cmp(string n, logic [31:0] x, s);
    num_checks++;
    if (s !== x) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic xf(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] x);
    xf(0, a, 0);
    cmp("rdata", x, r);
  endtask
  task automatic ck(fmp_master_t m, logic w, f, i, logic [15:0] a, p, logic g, u = 0);
    mdl.go(m, w, f, i, a, p);
    #1;
    cmp("grant", {31'h0, g}, {31'h0, resp.grant});
    cmp("data", g ? {16'h5a5a, a} : READ_NEUTRAL, chkRdata);
    cmp("puc", {31'h0, u}, {31'h0, pucReq});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    complete_run;
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1;
    rd(OFS_SEGRIGHT, {20'h0, RST_RIGHTS});
    rd(OFS_SYSTEM_CONFIG_REG0, 32'h0);
    rd(12'h0fc, 32'h0);
    cmp("slverr", 32'h1, {31'h0, e});
    ck(MST_CPU, 1, 0, 0, 16'h0100, 16'h0, 1);
    xf(1, OFS_SEGB1, 32'h1000);
    xf(1, OFS_SEGB2, 32'h2000);
    xf(1, OFS_SEGRIGHT, 32'hb35);
    xf(1, OFS_MASK, 32'h1);
    xf(1, OFS_SEGCTL, 32'h1);
    ck(MST_CPU, 1, 0, 0, 16'h0fff, 16'h0, 0);
    cmp("irq", 32'h1, {31'h0, irq});
    rd(OFS_STATUS, 32'h1);
    #1;
    cmp("irq", 32'h0, {31'h0, irq});
    ck(MST_CPU, 1, 0, 0, 16'h1000, 16'h0, 1);
    ck(MST_CPU, 0, 1, 0, 16'h1ffe, 16'h0, 0);
    ck(MST_CPU, 0, 1, 0, 16'h2000, 16'h0, 0, 1);
    ck(MST_CPU, 0, 0, 1, 16'h1800, 16'h0, 0);
    xf(1, OFS_SEGCTL, 32'h3);
    ck(MST_CPU, 0, 0, 1, 16'h1800, 16'h0, 1);
    rd(OFS_STATUS, 32'h9);
    xf(1, OFS_SEGCTL, 32'h2);
    xf(1, OFS_ENCLO, 32'h4000);
    xf(1, OFS_ENCHI, 32'h5000);
    xf(1, OFS_ENCCTL, 32'h1);
    ck(MST_CPU, 0, 0, 0, 16'h4010, 16'h4800, 1);
    ck(MST_CPU, 0, 0, 0, 16'h4010, 16'h3000, 0);
    ck(MST_DMA, 0, 0, 0, 16'h4ffe, 16'h4800, 0);
    ck(MST_DBG, 1, 0, 0, 16'h4000, 16'h4800, 0);
    xf(1, OFS_SYSTEM_CONFIG_REG0, 32'h1);
    ck(MST_CPU, 1, 0, 0, 16'h3000, 16'h0, 0);
    xf(1, OFS_WRREGION, 32'h1308);
    ck(MST_CPU, 1, 0, 0, 16'h2000, 16'h0, 1);
    ck(MST_CPU, 1, 0, 0, 16'h3000, 16'h0, 0);
    ck(MST_CPU, 1, 0, 1, 16'h1800, 16'h0, 1);
    xf(1, OFS_SYSTEM_CONFIG_REG0, 32'h3);
    ck(MST_CPU, 1, 0, 1, 16'h1800, 16'h0, 0);
    xf(1, OFS_MASK, 32'hf);
    @(posedge mclk);
    #1;
    cmp("irq", 32'h1, {31'h0, irq});
    @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    cmp("irq", 32'h0, {31'h0, irq});
    rd(OFS_SYSTEM_CONFIG_REG0, 32'h0);
    rd(OFS_STATUS, 32'h0);
    ck(MST_DMA, 1, 0, 0, 16'h4000, 16'h0, 1);
    complete_run;
  end
endmodule
`default_nettype wire
